// >>> rtl/ttc_pkg.sv
// Purpose: shared constants and types of the trace capture control block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   register offsets are byte addresses
`default_nettype none

package ttc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_WPTR   = 8'h0C;
    localparam logic [7:0] OFS_TAG    = 8'h10;
    localparam logic [7:0] OFS_LOST   = 8'h14;
    localparam logic [7:0] OFS_RADDR  = 8'h18;
    localparam logic [7:0] OFS_RKIND  = 8'h1C;
    localparam logic [7:0] OFS_RVALA  = 8'h20;
    localparam logic [7:0] OFS_RVALB  = 8'h24;
    localparam logic [7:0] OFS_RTAG   = 8'h28;

    // ****************************************
    // control field positions
    // ****************************************
    localparam int CTL_PREF_LSB  = 0;
    localparam int CTL_SRC_LSB   = 2;
    localparam int CTL_PRIO_BIT  = 5;
    localparam int CTL_CLR_BIT   = 6;
    localparam int CTL_POL_LSB   = 7;
    localparam int CTL_PRESC_LSB = 9;
    localparam int CTL_DEPTH_LSB = 13;
    localparam int CMD_CLR_BIT   = 0;

    // ****************************************
    // modes and encodings
    // ****************************************
    typedef enum logic [1:0] {
        PREF_TRACE   = 2'h0,
        PREF_MONITOR = 2'h1,
        PREF_COVER   = 2'h2
    } ttc_pref_t;

    typedef enum logic [2:0] {
        SRC_BPC       = 3'h0,
        SRC_ALLPC     = 3'h1,
        SRC_AD        = 3'h2,
        SRC_BPC_AD    = 3'h3,
        SRC_ALLPC_AD  = 3'h4,
        SRC_APC_AD    = 3'h5,
        SRC_BPC_APC_AD = 3'h6
    } ttc_src_t;

    typedef enum logic [1:0] {
        POL_WRAP      = 2'h0,
        POL_STOPTRACE = 2'h1,
        POL_STOP      = 2'h2
    } ttc_pol_t;

    // entry kinds, also bit index of the pending mask
    localparam int KIND_BSRC  = 0;
    localparam int KIND_BTGT  = 1;
    localparam int KIND_ALLPC = 2;
    localparam int KIND_APC   = 3;
    localparam int KIND_ADATA = 4;
    localparam int KIND_DMAS  = 5;
    localparam int KIND_DMAE  = 6;
    localparam int NKIND      = 7;

    // depth codes: 8K, 32K, 64K, 128K, 256K frames as log2
    localparam logic [4:0] DEPTH_LOG2_0 = 5'd13;
    localparam logic [4:0] DEPTH_LOG2_1 = 5'd15;
    localparam logic [4:0] DEPTH_LOG2_2 = 5'd16;
    localparam logic [4:0] DEPTH_LOG2_3 = 5'd17;
    localparam logic [4:0] DEPTH_LOG2_4 = 5'd18;
    localparam logic [3:0] PRESC_MAX    = 4'd12;

    // reset values
    localparam logic [1:0] RST_PREF  = PREF_MONITOR;
    localparam logic [2:0] RST_SRC   = SRC_BPC_AD;
    localparam logic       RST_CLR   = 1'b1;
    localparam logic [1:0] RST_POL   = POL_WRAP;
    localparam logic [3:0] RST_PRESC = 4'h0;
    localparam logic [2:0] RST_DEPTH = 3'h0;

endpackage : ttc_pkg

`default_nettype wire

// >>> rtl/ttc_capture.sv
// What this block does
// R1 - CPU items captured only while the program runs; halting stops them, DMA points still recorded.
// R2 - preference selects trace, monitor or coverage; trace disables the other two.
// R3 - monitor or coverage preferred: branch-only capture, trace events disabled.
// R4 - after reset the real-time memory monitor is preferred.
// R5 - seven trace sources; branch PC plus access data is default.
// R6 - a taken branch records source PC and target PC.
// R7 - all-PC records every PC; access data and access PC as selected.
// R8 - DMA start and end recorded whatever the source selection, but dropped while cpu_stall is high.
// R9 - speed priority never stalls the CPU; excess data is lost.
// R10 - data priority with trace preferred stalls the pipeline so no data drops; DMA points arriving while cpu_stall is high are dropped.
// R11 - clear-before-run, default on, clears memory when execution starts.
// R12 - wrap policy overwrites oldest entries once full.
// R13 - wrap with clear-before-run clears at resume, restarting empty.
// R14 - stop-trace policy: full memory ends writes, CPU keeps running.
// R15 - stop-trace without clear: full memory stays closed on restart.
// R16 - stop policy: full memory ends writes and requests a break.
// R17 - stop without clear: break request held while memory full.
// R18 - each entry carries a 32-bit time tag from the external clock.
// R19 - prescaler divides by any power of two from 1 to 4096.
// R20 - depth 8K, 32K, 64K, 128K or 256K frames; default 8K.
// R21 - clearing resets pointer and full; full set when pointer wraps.
//
// Purpose: trace capture controller with AHB-Lite register access
// Assumes: CPU holds its event inputs while cpu_stall is high
// Notes:   tag_clk is sampled on mclk; it must be slower than mclk/2
`default_nettype none

module ttc_capture #(
    parameter int AW  = 18,
    parameter int CHW = 8
) (
    input  wire logic            mclk,
    input  wire logic            sys_rst,
    // ahb-lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    // cpu execution side
    input  wire logic            cpu_running,
    input  wire logic            insn_valid,
    input  wire logic [31:0]     insn_pc,
    input  wire logic            br_taken,
    input  wire logic [31:0]     br_target,
    input  wire logic            acc_valid,
    input  wire logic            acc_write,
    input  wire logic [31:0]     acc_addr,
    input  wire logic [31:0]     acc_data,
    input  wire logic [31:0]     acc_pc,
    input  wire logic            dma_start,
    input  wire logic            dma_end,
    input  wire logic [CHW-1:0]  dma_chan,
    input  wire logic            tag_clk,
    output logic                 cpu_stall,
    output logic                 break_req,
    output logic                 trace_evt,
    output logic                 monitor_en,
    output logic                 coverage_en
);
    import ttc_pkg::*;

    localparam int ENT_W = 3 + 1 + 32 + 32 + 32;

    typedef struct packed {
        logic [1:0]        pref;
        logic [2:0]        src;
        logic              data_prio;
        logic              clr_run;
        logic [1:0]        pol;
        logic [3:0]        presc;
        logic [2:0]        depth;
        logic [AW-1:0]     raddr;
        logic [AW-1:0]     wptr;
        logic              full;
        logic              run;
        logic [NKIND-1:0]  pend;
        logic [31:0]       p_pc;
        logic [31:0]       p_tgt;
        logic [31:0]       p_apc;
        logic [31:0]       p_addr;
        logic [31:0]       p_data;
        logic              p_wr;
        logic [CHW-1:0]    p_chan;
        logic [31:0]       tag;
        logic [11:0]       pcnt;
        logic              tagclk;
        logic [31:0]       lost;
        logic              ap_valid;
        logic              ap_write;
        logic [7:0]        ap_addr;
        logic [31:0]       rdata;
        logic              evt;
    } ttc_state_t;

    ttc_state_t          s_q;
    ttc_state_t          s_d;
    logic [ENT_W-1:0]    mem [0:(1<<AW)-1];
    logic [ENT_W-1:0]    mem_rd_q;
    logic                mem_we;
    logic [ENT_W-1:0]    ent;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [AW-1:0] depth_last(input logic [2:0] code);
        logic [4:0] lg;
        case (code)
            3'h0:    lg = DEPTH_LOG2_0;
            3'h1:    lg = DEPTH_LOG2_1;
            3'h2:    lg = DEPTH_LOG2_2;
            3'h3:    lg = DEPTH_LOG2_3;
            default: lg = DEPTH_LOG2_4;
        endcase
        // depth larger than the built memory falls back to the full array
        if (int'(lg) > AW) begin
            lg = 5'(AW);
        end
        return AW'(((64'h1 << lg) - 64'h1));
    endfunction : depth_last

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [NKIND-1:0] req;
        logic             ld;
        logic             clr;
        logic             wr_ok;
        logic             want_b;
        logic             want_all;
        logic             want_ad;
        logic             want_apc;
        logic             found;
        logic [2:0]       kind;
        logic [11:0]      pmask;
        logic             tick;
        logic [2:0]       esrc;
        logic             ap;
        req      = '0;
        ld       = 1'b0;
        clr      = 1'b0;
        found    = 1'b0;
        kind     = 3'h0;
        ent      = '0;
        mem_we   = 1'b0;
        s_d      = s_q;
        s_d.evt  = 1'b0;

        // time tag: sampled clock edge through power-of-two prescaler
        // R19 power-of-two prescaler
        pmask = 12'((13'h1 << s_q.presc) - 13'h1);
        s_d.tagclk = tag_clk;
        tick = 1'b0;
        if (tag_clk && !s_q.tagclk) begin
            if ((s_q.pcnt & pmask) == pmask) begin
                s_d.pcnt = '0;
                tick     = 1'b1;
            end else begin
                s_d.pcnt = s_q.pcnt + 12'h1;
            end
        end
        // R18 32-bit tag counter
        if (tick) begin
            s_d.tag = s_q.tag + 32'h1;
        end

        // R3 non-trace preference forces branch PC
        esrc = (s_q.pref == PREF_TRACE) ? s_q.src : SRC_BPC;
        // R5 source decode
        want_b   = (esrc == SRC_BPC) || (esrc == SRC_BPC_AD) || (esrc == SRC_BPC_APC_AD);
        want_all = (esrc == SRC_ALLPC) || (esrc == SRC_ALLPC_AD);
        want_ad  = (esrc == SRC_AD) || (esrc == SRC_BPC_AD) || (esrc == SRC_ALLPC_AD)
                   || (esrc == SRC_APC_AD) || (esrc == SRC_BPC_APC_AD);
        want_apc = (esrc == SRC_APC_AD) || (esrc == SRC_BPC_APC_AD);

        // R1 cpu items only while running
        if (cpu_running) begin
            // R6 branch source and target
            req[KIND_BSRC]  = want_b && insn_valid && br_taken;
            req[KIND_BTGT]  = want_b && insn_valid && br_taken;
            // R7 all PC, access PC, access data
            req[KIND_ALLPC] = want_all && insn_valid;
            req[KIND_APC]   = want_apc && acc_valid;
            req[KIND_ADATA] = want_ad && acc_valid;
        end
        // R8 dma points bypass selection
        req[KIND_DMAS] = dma_start;
        req[KIND_DMAE] = dma_end;

        // R11 clear at start of execution, R13 also on resume
        clr = (cpu_running && !s_q.run && s_q.clr_run);
        s_d.run = cpu_running;

        // R14 stop policies close writes when full, R15 until cleared
        wr_ok = !(s_q.full && (s_q.pol != POL_WRAP));

        // drain one pending item per cycle, lowest kind first
        for (int k = 0; k < NKIND; k++) begin
            if (!found && s_q.pend[k]) begin
                found = 1'b1;
                kind  = 3'(k);
            end
        end
        if (found) begin
            s_d.pend[kind] = 1'b0;
            ent[ENT_W-1 -: 3] = kind;
            ent[31:0]         = s_q.tag;
            case (kind)
                3'(KIND_BSRC):  ent[95:64] = s_q.p_pc;
                3'(KIND_BTGT):  ent[95:64] = s_q.p_tgt;
                3'(KIND_ALLPC): ent[95:64] = s_q.p_pc;
                3'(KIND_APC):   ent[95:64] = s_q.p_apc;
                3'(KIND_ADATA): begin
                    ent[96]    = s_q.p_wr;
                    ent[95:64] = s_q.p_addr;
                    ent[63:32] = s_q.p_data;
                end
                default: ent[64 +: CHW] = s_q.p_chan;
            endcase
            if (wr_ok) begin
                mem_we = 1'b1;
                // R3 trace events only when trace preferred
                s_d.evt = (s_q.pref == PREF_TRACE);
                // R21 full on wrap past configured depth
                if (s_q.wptr == depth_last(s_q.depth)) begin
                    s_d.wptr = '0;
                    s_d.full = 1'b1;
                end else begin
                    s_d.wptr = s_q.wptr + AW'(1);
                end
            end
        end

        // R9 speed priority: newer items replace an undrained set
        // R10 data priority: cpu is stalled and holds its items
        ld = (req != '0) && !cpu_stall;
        if (ld) begin
            if (s_d.pend != '0) begin
                s_d.lost = s_q.lost + 32'h1;
            end
            s_d.pend   = req;
            s_d.p_pc   = insn_pc;
            s_d.p_tgt  = br_target;
            s_d.p_apc  = acc_pc;
            s_d.p_addr = acc_addr;
            s_d.p_data = acc_data;
            s_d.p_wr   = acc_write;
            s_d.p_chan = dma_chan;
        end

        // ahb-lite: data phase write, address phase read capture
        if (s_q.ap_valid && s_q.ap_write) begin
            case (s_q.ap_addr)
                OFS_CTRL: begin
                    // R2 preference selector
                    s_d.pref      = hwdata[CTL_PREF_LSB +: 2];
                    // R5 source selector
                    s_d.src       = (hwdata[CTL_SRC_LSB +: 3] > SRC_BPC_APC_AD)
                                    ? s_q.src : hwdata[CTL_SRC_LSB +: 3];
                    s_d.data_prio = hwdata[CTL_PRIO_BIT];
                    s_d.clr_run   = hwdata[CTL_CLR_BIT];
                    s_d.pol       = hwdata[CTL_POL_LSB +: 2];
                    // R19 ratio capped at 1/4096
                    s_d.presc     = (hwdata[CTL_PRESC_LSB +: 4] > PRESC_MAX)
                                    ? PRESC_MAX : hwdata[CTL_PRESC_LSB +: 4];
                    // R20 depth code
                    s_d.depth     = hwdata[CTL_DEPTH_LSB +: 3];
                end
                OFS_CMD:   clr = clr || hwdata[CMD_CLR_BIT];
                OFS_RADDR: s_d.raddr = hwdata[AW-1:0];
                default: ;
            endcase
        end

        // R21 clear resets pointer and full flag
        if (clr) begin
            s_d.wptr = '0;
            s_d.full = 1'b0;
            s_d.lost = '0;
        end

        ap = hsel && htrans[1] && hready;
        if (hready) begin
            s_d.ap_valid = ap;
            s_d.ap_write = hwrite;
            s_d.ap_addr  = haddr[7:0];
        end
        if (ap && !hwrite) begin
            case (haddr[7:0])
                OFS_CTRL:   s_d.rdata = (32'(s_q.depth) << CTL_DEPTH_LSB)
                                        | (32'(s_q.presc) << CTL_PRESC_LSB)
                                        | (32'(s_q.pol) << CTL_POL_LSB)
                                        | (32'(s_q.clr_run) << CTL_CLR_BIT)
                                        | (32'(s_q.data_prio) << CTL_PRIO_BIT)
                                        | (32'(s_q.src) << CTL_SRC_LSB)
                                        | (32'(s_q.pref) << CTL_PREF_LSB);
                OFS_STATUS: s_d.rdata = {27'h0, (s_q.pend != '0), cpu_stall,
                                         break_req, s_q.run, s_q.full};
                OFS_WPTR:   s_d.rdata = 32'(s_q.wptr);
                OFS_TAG:    s_d.rdata = s_q.tag;
                OFS_LOST:   s_d.rdata = s_q.lost;
                OFS_RADDR:  s_d.rdata = 32'(s_q.raddr);
                OFS_RKIND:  s_d.rdata = {28'h0, mem_rd_q[ENT_W-1 -: 4]};
                OFS_RVALA:  s_d.rdata = mem_rd_q[95:64];
                OFS_RVALB:  s_d.rdata = mem_rd_q[63:32];
                OFS_RTAG:   s_d.rdata = mem_rd_q[31:0];
                default:    s_d.rdata = 32'h0;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q           <= '0;
            // R4 monitor preferred after reset
            s_q.pref      <= RST_PREF;
            s_q.src       <= RST_SRC;
            s_q.clr_run   <= RST_CLR;
            s_q.pol       <= RST_POL;
            s_q.presc     <= RST_PRESC;
            s_q.depth     <= RST_DEPTH;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // trace memory
    // ****************************************
    // R12 overwrite oldest when wrapping
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[s_q.wptr] <= ent;
        end
        mem_rd_q <= mem[s_q.raddr];
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = s_q.rdata;
    // R10 stall only under data priority with trace preferred
    assign cpu_stall   = s_q.data_prio && (s_q.pref == PREF_TRACE) && (s_q.pend != '0);
    // R16 break on full, R17 held until cleared
    assign break_req   = s_q.full && (s_q.pol == POL_STOP);
    assign trace_evt   = s_q.evt;
    // R2 exclusive use of shared resources
    assign monitor_en  = (s_q.pref == PREF_MONITOR);
    assign coverage_en = (s_q.pref == PREF_COVER);

endmodule : ttc_capture

`default_nettype wire

// >>> verification/ttc_capture_asserts.sv
// Purpose: port checker for ttc_capture
// Assumes: zero-wait slave, CTRL mode fields in bits 8:0
// Notes:   shadows CTRL writes to judge the mode outputs
`default_nettype none
module ttc_capture_chk import ttc_pkg::*; (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        cpu_stall,
    input wire logic        break_req,
    input wire logic        trace_evt,
    input wire logic        monitor_en,
    input wire logic        coverage_en
);
    // ****
    // shadow of the control word
    // ****
    logic [2:0] dp_q;
    logic [8:0] ctl_q;
    wire logic  ap = hsel && htrans[1] && hready;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dp_q  <= 3'h0;
            ctl_q <= {RST_POL, RST_CLR, 1'b0, RST_SRC, RST_PREF};
        end else begin
            dp_q <= {ap && !hwrite && haddr[31:8] == 24'h0 && haddr[7:0] > OFS_RTAG,
                     ap && hwrite && haddr[7:0] == OFS_CTRL, ap && hwrite};
            if (dp_q[1] && hready) ctl_q <= hwdata[8:0];
        end
    end
    // ****
    // checks
    // ****
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_reset_pref: assert property ($fell(sys_rst) |-> monitor_en && !coverage_en)
        else $error("monitor not preferred after reset");
    a_pref_outputs: assert property (monitor_en == (ctl_q[1:0] == PREF_MONITOR)
        && coverage_en == (ctl_q[1:0] == PREF_COVER)) else $error("mode outputs wrong");
    a_speed_no_stall: assert property (cpu_stall |-> ctl_q[5] && ctl_q[1:0] == PREF_TRACE)
        else $error("stall outside data priority");
    a_evt_trace_only: assert property (trace_evt |-> $past(ctl_q[1:0]) == PREF_TRACE)
        else $error("trace event while not preferred");
    a_break_policy: assert property (break_req |-> ctl_q[8:7] == POL_STOP)
        else $error("break outside stop policy");
    a_break_held: assert property (break_req && !ctl_q[6] && !dp_q[0] |=> break_req)
        else $error("break dropped while full");
    a_unmapped_zero: assert property (dp_q[2] |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    c_stall: cover property (cpu_stall);
    c_break: cover property (break_req);
    c_event: cover property (trace_evt);
endmodule : ttc_capture_chk
bind ttc_capture ttc_capture_chk i_chk (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .cpu_stall, .break_req, .trace_evt,
    .monitor_en, .coverage_en);
`default_nettype wire

// >>> verification/ttc_cpu_model.sv
// Purpose: cpu model issuing instructions to the capture block
// Assumes: pc steps by four, one instruction per issue
// Notes:   freezes whole while stalled, holding its items
`default_nettype none
module ttc_cpu_model (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        go,
    input  wire logic [7:0]  n,
    input  wire logic        br_on,
    input  wire logic        acc_on,
    input  wire logic        burst,
    input  wire logic        cpu_stall,
    input  wire logic        break_req,
    output logic             cpu_running,
    output logic             insn_valid,
    output logic [31:0]      insn_pc,
    output logic             br_taken,
    output logic [31:0]      br_target,
    output logic             acc_valid,
    output logic             acc_write,
    output logic [31:0]      acc_addr,
    output logic [31:0]      acc_data,
    output logic [31:0]      acc_pc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  left;
    logic [31:0] pc;
    logic        gap_q;
    wire logic   issue;
    initial {cpu_running, insn_valid, br_taken, acc_valid, acc_write} = '0;
    initial {insn_pc, br_target, acc_addr, acc_data, acc_pc} = '0;
    // hold off while stalled or on break
    assign issue = cpu_running && left != 8'h0 && !cpu_stall && !break_req
                   && !((insn_valid || gap_q) && !burst);
    always @(posedge mclk) begin
        if (sys_rst) begin
            left        <= 8'h0;
            pc          <= 32'h0;
            cpu_running <= 1'b0;
            insn_valid  <= 1'b0;
            gap_q       <= 1'b0;
        end else if (!cpu_stall) begin
            // restart refused while break is held
            if (go && !break_req) begin
                left        <= n;
                cpu_running <= 1'b1;
            end else if (break_req || (left == 8'h0 && !insn_valid)) begin
                cpu_running <= 1'b0;
            end
            if (issue) left <= left - 8'h1;
            if (issue) pc <= pc + 32'h4;
            gap_q      <= insn_valid;
            insn_valid <= issue;
            br_taken   <= issue && br_on;
            acc_valid  <= issue && acc_on;
            insn_pc    <= issue ? pc : ~insn_pc;
            acc_addr   <= issue ? pc + 32'h1000 : ~acc_addr;
            br_target  <= pc + 32'h100;
            acc_data   <= ~pc;
            acc_pc     <= pc;
            acc_write  <= 1'b1;
        end
    end
endmodule : ttc_cpu_model
`default_nettype wire

// >>> verification/ttc_capture_tb_top.sv
// Purpose: directed bench for ttc_capture
// Assumes: AW=6, so every depth code holds 64 entries
// Notes:   bus tasks leave one idle cycle after each transfer
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module ttc_capture_tb_top import ttc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0, go = 0, br_on = 0, acc_on = 0;
    logic        burst = 0, tag_clk = 0, dma_start = 0, dma_end = 0;
    logic [31:0] haddr = '0, hwdata = '0, v, t0;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  n = '0, dma_chan = '0;
    wire logic   hreadyout, hresp, cpu_stall, break_req, trace_evt, monitor_en, coverage_en;
    wire logic   cpu_running, insn_valid, br_taken, acc_valid, acc_write;
    wire logic [31:0] hrdata, insn_pc, br_target, acc_addr, acc_data, acc_pc;
    int          err_total = 0, tests_run = 0, evt_n = 0;
    ttc_capture #(.AW(6), .CHW(8)) i_dut (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cpu_running,
        .insn_valid, .insn_pc, .br_taken, .br_target, .acc_valid, .acc_write, .acc_addr,
        .acc_data, .acc_pc, .dma_start, .dma_end, .dma_chan, .tag_clk, .cpu_stall, .break_req,
        .trace_evt, .monitor_en, .coverage_en);
    ttc_cpu_model i_cpu (.mclk, .sys_rst, .go, .n, .br_on, .acc_on, .burst, .cpu_stall,
        .break_req, .cpu_running, .insn_valid, .insn_pc, .br_taken, .br_target, .acc_valid,
        .acc_write, .acc_addr, .acc_data, .acc_pc);
    // ****
    // tasks
    // ****
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        v = hrdata;
        hsel <= 1'b0;
        @(posedge mclk);
    endtask : xfer
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, e, v)
    endtask : rchk
    task automatic ent(input logic [7:0] i, input logic [31:0] k, input logic [31:0] a);
        xfer(1'b1, OFS_RADDR, {24'h0, i});
        rchk("kind", OFS_RKIND, k);
        rchk("val_a", OFS_RVALA, a);
    endtask : ent
    task automatic run(input logic [7:0] k);
        go <= 1'b1;
        n  <= k;
        @(posedge mclk);
        go <= 1'b0;
        for (int i = 0; i < 900 && (i < 3 || cpu_running === 1'b1); i++) @(posedge mclk);
        repeat (6) @(posedge mclk);
    endtask : run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    // ****
    // sequence
    // ****
    initial forever #20 mclk = ~mclk;
    always @(posedge mclk) if (trace_evt === 1'b1) evt_n++;
    initial begin
        #2000000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rchk("ctrl", OFS_CTRL, 32'h4D);
        `CHK("mon", 1'b1, monitor_en)
        rchk("stat", OFS_STATUS, 32'h0);
        xfer(1'b1, 8'h3C, 32'hFFFF_FFFF);
        rchk("unmapped", 8'h3C, 32'h0);
        xfer(1'b1, OFS_CTRL, 32'h9E5D);
        rchk("ctrl_sat", OFS_CTRL, 32'h984D);
        xfer(1'b1, OFS_CTRL, 32'h44D);
        xfer(1'b0, OFS_TAG, 32'h0);
        t0 = v;
        repeat (8) begin
            @(posedge mclk) tag_clk <= 1'b1;
            @(posedge mclk) tag_clk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        rchk("tag", OFS_TAG, t0 + 32'h2);
        xfer(1'b1, OFS_CTRL, 32'h60);
        `CHK("mon", 1'b0, monitor_en)
        {br_on, burst} <= 2'b11;
        run(8'd3);
        rchk("wptr", OFS_WPTR, 32'h6);
        ent(8'h0, 32'h0, 32'h0);
        ent(8'h1, 32'h2, 32'h100);
        run(8'd2);
        rchk("wptr", OFS_WPTR, 32'h4);
        xfer(1'b1, OFS_CTRL, 32'h40);
        run(8'd4);
        burst <= 1'b0;
        xfer(1'b0, OFS_LOST, 32'h0);
        `CHK("lost", 1'b1, v !== 32'h0)
        xfer(1'b1, OFS_CTRL, 32'h45);
        br_on <= 1'b0;
        run(8'd3);
        rchk("wptr", OFS_WPTR, 32'h0);
        xfer(1'b1, OFS_CTRL, 32'h46);
        `CHK("cov", 2'h2, {coverage_en, monitor_en})
        br_on <= 1'b1;
        run(8'd2);
        rchk("wptr", OFS_WPTR, 32'h4);
        xfer(1'b1, OFS_CTRL, 32'h68);
        {br_on, acc_on} <= 2'b01;
        evt_n = 0;
        run(8'd3);
        rchk("wptr", OFS_WPTR, 32'h3);
        `CHK("evt", 3, evt_n)
        ent(8'h0, 32'h9, 32'h1038);
        rchk("val_b", OFS_RVALB, 32'hFFFF_FFC7);
        xfer(1'b1, OFS_CTRL, 32'h60);
        xfer(1'b1, OFS_CMD, 32'h1);
        rchk("wptr", OFS_WPTR, 32'h0);
        dma_chan  <= 8'h5A;
        dma_start <= 1'b1;
        @(posedge mclk) dma_start <= 1'b0;
        @(posedge mclk) dma_end <= 1'b1;
        @(posedge mclk) dma_end <= 1'b0;
        repeat (4) @(posedge mclk);
        rchk("wptr", OFS_WPTR, 32'h2);
        ent(8'h0, 32'hA, 32'h5A);
        ent(8'h1, 32'hC, 32'h5A);
        {br_on, acc_on} <= 2'b00;
        for (int p = 0; p < 3; p++) begin
            xfer(1'b1, OFS_CTRL, 32'h24 | (32'(p) << 7));
            xfer(1'b1, OFS_CMD, 32'h1);
            run(8'd70);
            rchk("stat", OFS_STATUS, p == 2 ? 32'h5 : 32'h1);
            rchk("wptr", OFS_WPTR, p == 0 ? 32'h6 : 32'h0);
            run(8'd3);
            rchk("wptr", OFS_WPTR, p == 0 ? 32'h9 : 32'h0);
        end
        rchk("stat", OFS_STATUS, 32'h5);
        xfer(1'b1, OFS_CMD, 32'h1);
        rchk("stat", OFS_STATUS, 32'h0);
        give_verdict();
    end
endmodule : ttc_capture_tb_top
`default_nettype wire
